// [crit_limit_bank.sv]
// Purpose: Critical limit, hysteresis, status and identification registers.
// Assumes: Avalon-MM slave with waitrequest; strap pins steady at reset.
// Notes:   Every access takes two cycles; a read of status clears the bits it returned.
`timescale 1ns/1ps
module crit_limit_bank (
    input  wire logic        core_clk,             // 20 MHz clock
    input  wire logic        nrst,                 // Async reset, active low
    input  wire logic [9:0]  avs_address,          // Byte address
    input  wire logic        avs_read,             // Read request
    input  wire logic        avs_write,            // Write request
    input  wire logic [31:0] avs_writedata,        // Write data
    input  wire logic [3:0]  avs_byteenable,       // Byte enables
    output logic      [31:0] avs_readdata,         // Read data
    output logic             avs_waitrequest,      // Stall, high holds master
    output logic             irq,                  // Level interrupt
    input  wire logic [11:0] sense_voltage,        // Signed sense sample
    input  wire logic [11:0] source_voltage,       // Unsigned source sample
    input  wire logic        meas_update,          // New samples, one pulse
    input  wire logic [3:0]  peak_threshold_strap, // Threshold strap code
    input  wire logic [3:0]  peak_duration_strap,  // Duration strap code
    output logic             critical_alert_n,     // Critical alert, low
    output logic      [3:0]  peak_threshold_field, // Threshold default
    output logic      [3:0]  peak_duration_field   // Duration default
);
    crit_chan_if sense_ch ();
    crit_chan_if source_ch ();

    crit_pkg::bus_state_e bus_state_reg;
    crit_pkg::bus_state_e bus_state_next;
    logic        waitrequest_reg;
    logic        waitrequest_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;

    logic [7:0]  sense_limit_reg;
    logic [7:0]  sense_limit_next;
    logic [7:0]  source_limit_reg;
    logic [7:0]  source_limit_next;
    logic [4:0]  sense_hyst_reg;
    logic [4:0]  sense_hyst_next;
    logic [4:0]  source_hyst_reg;
    logic [4:0]  source_hyst_next;
    logic [1:0]  status_reg;
    logic [1:0]  status_next;
    logic [1:0]  mask_reg;
    logic [1:0]  mask_next;
    logic        irq_reg;
    logic        irq_next;
    logic        alert_n_reg;
    logic        alert_n_next;

    logic [7:0]  features_reg;
    logic [7:0]  features_next;
    logic        captured_reg;
    logic        captured_next;

    logic [7:0]  index;
    logic        word_ok;
    logic        commit;
    logic        wr_lane0;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic [1:0]  events;
    logic [1:0]  clear_bits;

    assign sense_ch.update  = meas_update;
    assign source_ch.update = meas_update;
    assign sense_ch.sample  =
        sense_voltage[crit_pkg::MEAS_MSB:crit_pkg::MEAS_TOP_LSB];
    assign source_ch.sample =
        source_voltage[crit_pkg::MEAS_MSB:crit_pkg::MEAS_TOP_LSB];
    assign sense_ch.limit   = sense_limit_reg;
    assign source_ch.limit  = source_limit_reg;
    assign sense_ch.hyst    = sense_hyst_reg;
    assign source_ch.hyst   = source_hyst_reg;

    crit_compare #(
        .IS_SIGNED (1'b1)
    ) u_sense_cmp (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ch       (sense_ch)
    );

    crit_compare #(
        .IS_SIGNED (1'b0)
    ) u_source_cmp (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ch       (source_ch)
    );

    // Read decode; unmapped and reserved bits read as zero.
    always_comb begin
        index   = avs_address[9:2];
        word_ok = avs_address[1:0] == 2'h0;
        rbyte   = 8'h00;
        if (word_ok) begin
            case (index)
                crit_pkg::IDX_SENSE_LIMIT:  rbyte = sense_limit_reg;
                crit_pkg::IDX_SOURCE_LIMIT: rbyte = source_limit_reg;
                crit_pkg::IDX_SENSE_HYST:   rbyte = {3'h0, sense_hyst_reg};
                crit_pkg::IDX_SOURCE_HYST:  rbyte = {3'h0, source_hyst_reg};
                crit_pkg::IDX_CRIT_STATUS:  rbyte = {6'h00, status_reg};
                crit_pkg::IDX_CRIT_MASK:    rbyte = {6'h00, mask_reg};
                crit_pkg::IDX_FEATURES:     rbyte = features_reg;
                crit_pkg::IDX_PART_ID:
                    rbyte = crit_pkg::PART_ID_VALUE;
                crit_pkg::IDX_MAKER_ID:     rbyte = crit_pkg::MAKER_ID_VALUE;
                crit_pkg::IDX_REVISION:
                    rbyte = crit_pkg::REVISION_VALUE;
                default:                    rbyte = 8'h00;
            endcase
        end
    end

    // Bus handshake: one stall cycle, then one cycle with waitrequest low.
    always_comb begin
        bus_state_next   = bus_state_reg;
        waitrequest_next = 1'b1;
        readdata_next    = readdata_reg;
        case (bus_state_reg)
            crit_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_state_next   = crit_pkg::BUS_ACK;
                    waitrequest_next = 1'b0;
                    readdata_next    = avs_read ? {24'h000000, rbyte}
                                                : 32'h00000000;
                end
            end
            crit_pkg::BUS_ACK: begin
                bus_state_next   = crit_pkg::BUS_IDLE;
                waitrequest_next = 1'b1;
            end
            default: begin
                bus_state_next   = crit_pkg::BUS_IDLE;
                waitrequest_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus_state_reg   <= crit_pkg::BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg    <= 32'h00000000;
        end else begin
            bus_state_reg   <= bus_state_next;
            waitrequest_reg <= waitrequest_next;
            readdata_reg    <= readdata_next;
        end
    end

    // Register writes and the side effects of a completed access.
    always_comb begin
        commit   = bus_state_reg == crit_pkg::BUS_ACK;
        wr_lane0 = commit && avs_write && avs_byteenable[0] && word_ok;
        wbyte    = avs_writedata[7:0];
        sense_limit_next  = sense_limit_reg;
        source_limit_next = source_limit_reg;
        sense_hyst_next   = sense_hyst_reg;
        source_hyst_next  = source_hyst_reg;
        mask_next         = mask_reg;
        if (wr_lane0) begin
            case (index)
                crit_pkg::IDX_SENSE_LIMIT:  sense_limit_next  = wbyte;
                crit_pkg::IDX_SOURCE_LIMIT: source_limit_next = wbyte;
                crit_pkg::IDX_SENSE_HYST:
                    sense_hyst_next = wbyte[crit_pkg::HYST_WIDTH-1:0];
                crit_pkg::IDX_SOURCE_HYST:
                    source_hyst_next = wbyte[crit_pkg::HYST_WIDTH-1:0];
                crit_pkg::IDX_CRIT_MASK:    mask_next = wbyte[1:0];
                default:                    mask_next = mask_reg;
            endcase
        end
        events = {source_ch.crossed, sense_ch.crossed};
        // Only bits that the read returned are cleared, so a crossing that
        // lands during the access survives to the next read.
        clear_bits = (commit && avs_read && word_ok &&
                      index == crit_pkg::IDX_CRIT_STATUS)
                     ? readdata_reg[1:0] : 2'h0;
        status_next = (status_reg & ~clear_bits) | events;
        irq_next    = |(status_next & ~mask_next);
        alert_n_next = ~(sense_ch.active | source_ch.active);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sense_limit_reg  <= crit_pkg::RST_SENSE_LIMIT;
            source_limit_reg <= crit_pkg::RST_SOURCE_LIMIT;
            sense_hyst_reg   <= crit_pkg::RST_SENSE_HYST;
            source_hyst_reg  <= crit_pkg::RST_SOURCE_HYST;
            mask_reg         <= crit_pkg::RST_CRIT_MASK;
            status_reg       <= crit_pkg::RST_CRIT_STATUS;
            irq_reg          <= 1'b0;
            alert_n_reg      <= 1'b1;
        end else begin
            sense_limit_reg  <= sense_limit_next;
            source_limit_reg <= source_limit_next;
            sense_hyst_reg   <= sense_hyst_next;
            source_hyst_reg  <= source_hyst_next;
            mask_reg         <= mask_next;
            status_reg       <= status_next;
            irq_reg          <= irq_next;
            alert_n_reg      <= alert_n_next;
        end
    end

    // Straps are taken at the first edge after reset release; the reset
    // itself loads a constant so no port reaches an asynchronous load.
    always_comb begin
        features_next = features_reg;
        captured_next = 1'b1;
        if (!captured_reg) begin
            features_next[crit_pkg::FEAT_TH_MSB:crit_pkg::FEAT_TH_LSB] =
                peak_threshold_strap;
            features_next[crit_pkg::FEAT_DUR_MSB:crit_pkg::FEAT_DUR_LSB] =
                peak_duration_strap;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            features_reg <= crit_pkg::RST_FEATURES;
            captured_reg <= 1'b0;
        end else begin
            features_reg <= features_next;
            captured_reg <= captured_next;
        end
    end

    assign avs_readdata         = readdata_reg;
    assign avs_waitrequest      = waitrequest_reg;
    assign irq                  = irq_reg;
    assign critical_alert_n     = alert_n_reg;
    assign peak_threshold_field =
        features_reg[crit_pkg::FEAT_TH_MSB:crit_pkg::FEAT_TH_LSB];
    assign peak_duration_field  =
        features_reg[crit_pkg::FEAT_DUR_MSB:crit_pkg::FEAT_DUR_LSB];
endmodule : crit_limit_bank

// [crit_pkg.sv]
// Purpose: Shared constants for the critical limit and identification bank.
// Assumes: Register indices are word indices; byte address is four times.
// Notes:   Identification values are arbitrary and only name this build.
package crit_pkg;
    localparam logic [7:0] IDX_SENSE_LIMIT  = 8'h66;
    localparam logic [7:0] IDX_SOURCE_LIMIT = 8'h68;
    localparam logic [7:0] IDX_SENSE_HYST   = 8'h69;
    localparam logic [7:0] IDX_SOURCE_HYST  = 8'h6a;
    localparam logic [7:0] IDX_CRIT_STATUS  = 8'h70;
    localparam logic [7:0] IDX_CRIT_MASK    = 8'h71;
    localparam logic [7:0] IDX_FEATURES     = 8'hfc;
    localparam logic [7:0] IDX_PART_ID      = 8'hfd;
    localparam logic [7:0] IDX_MAKER_ID     = 8'hfe;
    localparam logic [7:0] IDX_REVISION     = 8'hff;

    localparam logic [7:0] RST_SENSE_LIMIT  = 8'h7f;
    localparam logic [7:0] RST_SOURCE_LIMIT = 8'hff;
    localparam logic [4:0] RST_SENSE_HYST   = 5'h0a;
    localparam logic [4:0] RST_SOURCE_HYST  = 5'h0a;
    localparam logic [7:0] RST_FEATURES     = 8'h00;
    localparam logic [1:0] RST_CRIT_STATUS  = 2'h0;
    localparam logic [1:0] RST_CRIT_MASK    = 2'h0;

    // Arbitrary identification values.
    localparam logic [7:0] PART_ID_VALUE    = 8'h5a;
    localparam logic [7:0] MAKER_ID_VALUE   = 8'h4c;
    localparam logic [7:0] REVISION_VALUE   = 8'h13;

    localparam int FEAT_TH_MSB   = 7;
    localparam int FEAT_TH_LSB   = 4;
    localparam int FEAT_DUR_MSB  = 3;
    localparam int FEAT_DUR_LSB  = 0;
    localparam int STAT_SENSE    = 0;
    localparam int STAT_SOURCE   = 1;
    localparam int MEAS_MSB      = 11;
    localparam int MEAS_TOP_LSB  = 4;
    localparam int HYST_WIDTH    = 5;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_e;
endpackage : crit_pkg

// [crit_chan_if.sv]
// Purpose: Carries one measured quantity between the bank and a comparator.
// Assumes: One clock domain; update is a one-cycle pulse.
// Notes:   The bank drives the sample and settings, the comparator the state.
`timescale 1ns/1ps
interface crit_chan_if;
    logic       update;
    logic [7:0] sample;
    logic [7:0] limit;
    logic [4:0] hyst;
    logic       active;
    logic       crossed;

    modport bank (output update, sample, limit, hyst, input active, crossed);
    modport cmp  (input update, sample, limit, hyst, output active, crossed);
endinterface : crit_chan_if

// [crit_compare.sv]
// Purpose: Critical limit comparator with hysteresis for one quantity.
// Assumes: Sample and limit share the sample's number format; hysteresis is unsigned.
// Notes:   IS_SIGNED selects two's complement compare for the sense channel.
`timescale 1ns/1ps
module crit_compare #(
    parameter bit IS_SIGNED = 1'b0
) (
    input wire logic core_clk, // 20 MHz clock
    input wire logic nrst,     // Asynchronous reset, active low
    crit_chan_if.cmp ch        // Channel to the register bank
);
    logic               active_reg;
    logic               active_next;
    logic               crossed_reg;
    logic               crossed_next;
    logic signed [9:0]  sample_ext;
    logic signed [9:0]  limit_ext;
    logic signed [9:0]  release_ext;
    logic               at_or_above;
    logic               below_release;

    // Ten bits hold limit minus the widest hysteresis without wrapping.
    always_comb begin
        sample_ext    = {{2{IS_SIGNED & ch.sample[7]}}, ch.sample};
        limit_ext     = {{2{IS_SIGNED & ch.limit[7]}}, ch.limit};
        release_ext   = limit_ext - $signed({5'h00, ch.hyst});
        at_or_above   = sample_ext >= limit_ext;
        below_release = sample_ext < release_ext;
        active_next   = active_reg;
        crossed_next  = 1'b0;
        if (ch.update) begin
            if (at_or_above) begin
                active_next  = 1'b1;
                crossed_next = 1'b1;
            end else if (below_release) begin
                active_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            active_reg  <= 1'b0;
            crossed_reg <= 1'b0;
        end else begin
            active_reg  <= active_next;
            crossed_reg <= crossed_next;
        end
    end

    assign ch.active  = active_reg;
    assign ch.crossed = crossed_reg;
endmodule : crit_compare

// [crit_limit_bank_assertions.sv]
// Purpose: Port-level checks of the critical limit bank.
// Assumes: One clock; nrst is asynchronous and active low.
// Notes:   Latencies match the two-cycle bus and the update pipeline.
`timescale 1ns/1ps
module crit_limit_bank_checker (
    input wire logic        core_clk,             // Clock
    input wire logic        nrst,                 // Reset, active low
    input wire logic [9:0]  avs_address,          // Byte address
    input wire logic        avs_read,             // Read request
    input wire logic        avs_write,            // Write request
    input wire logic [31:0] avs_readdata,         // Read data
    input wire logic        avs_waitrequest,      // Stall
    input wire logic        irq,                  // Interrupt
    input wire logic        meas_update,          // Sample pulse
    input wire logic [3:0]  peak_threshold_strap, // Threshold strap
    input wire logic [3:0]  peak_duration_strap,  // Duration strap
    input wire logic        critical_alert_n,     // Alert, low
    input wire logic [3:0]  peak_threshold_field, // Threshold field
    input wire logic [3:0]  peak_duration_field   // Duration field
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_one_stall_cycle: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    a_ack_single_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    a_alert_fall_cause: assert property ($fell(critical_alert_n)
        |-> $past(meas_update, 2)) else $error("alert fell unprompted");
    a_alert_rise_cause: assert property ($rose(critical_alert_n)
        |-> $past(meas_update, 2)) else $error("alert rose unprompted");
    a_irq_rise_cause: assert property ($rose(irq) |->
        $past(meas_update, 2) || $past(avs_write, 2))
        else $error("irq rose unprompted");
    a_fields_hold_still: assert property ($past(nrst, 2) |->
        $stable({peak_threshold_field, peak_duration_field}))
        else $error("fields changed");
    a_fields_from_strap: assert property (
        $past(nrst) && !$past(nrst, 2)
        |-> {peak_threshold_field, peak_duration_field} ==
        $past({peak_threshold_strap, peak_duration_strap}))
        else $error("fields not strapped");
    a_part_id_value: assert property (!avs_waitrequest && avs_read
        && avs_address == 10'h3f4 |->
        avs_readdata[7:0] == crit_pkg::PART_ID_VALUE)
        else $error("bad part id");
    a_revision_value: assert property (!avs_waitrequest && avs_read
        && avs_address == 10'h3fc |->
        avs_readdata[7:0] == crit_pkg::REVISION_VALUE) else $error("bad rev");

    c_alert_fall: cover property ($fell(critical_alert_n));
    c_irq_rise: cover property ($rose(irq));
    c_write_ack: cover property (!avs_waitrequest && avs_write);
endmodule : crit_limit_bank_checker

bind crit_limit_bank crit_limit_bank_checker u_crit_limit_bank_checker (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .meas_update(meas_update),
    .peak_threshold_strap(peak_threshold_strap),
    .peak_duration_strap(peak_duration_strap),
    .critical_alert_n(critical_alert_n),
    .peak_threshold_field(peak_threshold_field),
    .peak_duration_field(peak_duration_field));

// [crit_limit_bank_tb_top.sv]
// Purpose: Self-checking bench of the critical limit bank.
// Assumes: Bus answers through waitrequest; alert lags an update by two.
// Notes:   Status is read after each update, which also clears it.
`timescale 1ns/1ps
module crit_limit_bank_tb_top;
    typedef struct packed {
        logic [9:0] a;
        logic       w;
        logic       b;
        logic [7:0] d;
        logic [7:0] e;
    } row_s;
    logic        core_clk = 1'b0, nrst = 1'b0, meas_update = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'hf, th_strap = 4'h9, du_strap = 4'h6;
    logic [11:0] sense_v = 12'h000, source_v = 12'h000;
    logic        avs_waitrequest, irq, alert_n;
    logic [3:0]  th_field, du_field;
    logic [7:0]  q;
    int          fail_count = 0, checked = 0;
    row_s        rows [17] = '{
        '{10'h198, 1'b0, 1'b1, 8'h00, 8'h7f},
        '{10'h1a0, 1'b0, 1'b1, 8'h00, 8'hff},
        '{10'h1a4, 1'b0, 1'b1, 8'h00, 8'h0a},
        '{10'h1a8, 1'b0, 1'b1, 8'h00, 8'h0a},
        '{10'h1c4, 1'b0, 1'b1, 8'h00, 8'h00},
        '{10'h3f0, 1'b1, 1'b1, 8'h00, 8'h96},
        '{10'h3f4, 1'b1, 1'b1, 8'hff, 8'h5a},
        '{10'h3f8, 1'b0, 1'b1, 8'h00, 8'h4c},
        '{10'h3fc, 1'b1, 1'b1, 8'h00, 8'h13},
        '{10'h198, 1'b1, 1'b1, 8'h40, 8'h40},
        '{10'h198, 1'b1, 1'b0, 8'h11, 8'h40},
        '{10'h1a0, 1'b1, 1'b1, 8'h80, 8'h80},
        '{10'h1a4, 1'b1, 1'b1, 8'hff, 8'h1f},
        '{10'h1a4, 1'b1, 1'b1, 8'h04, 8'h04},
        '{10'h1a8, 1'b1, 1'b1, 8'h08, 8'h08},
        '{10'h3e0, 1'b1, 1'b1, 8'h55, 8'h00},
        '{10'h199, 1'b0, 1'b1, 8'h00, 8'h00}};

    always #25 core_clk = ~core_clk;

    crit_limit_bank u_crit_limit_bank (
        .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .sense_voltage(sense_v), .source_voltage(source_v),
        .meas_update(meas_update), .peak_threshold_strap(th_strap),
        .peak_duration_strap(du_strap), .critical_alert_n(alert_n),
        .peak_threshold_field(th_field), .peak_duration_field(du_field));

    task automatic end_sim;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // The request stays up until waitrequest is sampled low at an edge.
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [7:0] d, input logic b,
                       output logic [7:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= {3'h7, b};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        r = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            end_sim();
        end
    endtask : bus

    task automatic meas(input logic [7:0] s, v);
        @(posedge core_clk);
        sense_v <= {s, 4'h5};
        source_v <= {v, 4'ha};
        meas_update <= 1'b1;
        @(posedge core_clk);
        meas_update <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : meas

    task automatic outs(input logic a, i, input logic [7:0] st);
        chk("alert_n", {7'h0, a}, {7'h0, alert_n});
        chk("irq", {7'h0, i}, {7'h0, irq});
        bus(1'b0, 10'h1c0, 8'h00, 1'b1, q);
        chk("status", st, q);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq_after_read", 8'h00, {7'h0, irq});
    endtask : outs

    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        th_strap <= 4'h3;
        #1;
        chk("thr_field", 8'h09, {4'h0, th_field});
        chk("dur_field", 8'h06, {4'h0, du_field});
        foreach (rows[i]) begin
            if (rows[i].w)
                bus(1'b1, rows[i].a, rows[i].d, rows[i].b, q);
            bus(1'b0, rows[i].a, 8'h00, 1'b1, q);
            chk("register", rows[i].e, q);
        end
        meas(8'h3f, 8'h7f);
        outs(1'b1, 1'b0, 8'h00);
        meas(8'h40, 8'h7f);
        outs(1'b0, 1'b1, 8'h01);
        meas(8'h3c, 8'h7f);
        outs(1'b0, 1'b0, 8'h00);
        meas(8'h3b, 8'h7f);
        outs(1'b1, 1'b0, 8'h00);
        meas(8'hc0, 8'h80);
        outs(1'b0, 1'b1, 8'h02);
        meas(8'h40, 8'h70);
        outs(1'b0, 1'b1, 8'h01);
        meas(8'h00, 8'h79);
        outs(1'b1, 1'b0, 8'h00);
        @(posedge core_clk);
        sense_v <= 12'h7f0;
        repeat (4) @(posedge core_clk);
        #1;
        chk("alert_no_update", 8'h01, {7'h0, alert_n});
        bus(1'b1, 10'h1c4, 8'h01, 1'b1, q);
        meas(8'h50, 8'h00);
        outs(1'b0, 1'b0, 8'h01);
        @(posedge core_clk);
        nrst <= 1'b0;
        #1;
        chk("alert_in_reset", 8'h01, {7'h0, alert_n});
        chk("wait_in_reset", 8'h01, {7'h0, avs_waitrequest});
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("thr_field_again", 8'h03, {4'h0, th_field});
        bus(1'b0, 10'h3f0, 8'h00, 1'b1, q);
        chk("features", 8'h36, q);
        bus(1'b0, 10'h198, 8'h00, 1'b1, q);
        chk("limit_reset", 8'h7f, q);
        end_sim();
    end
endmodule : crit_limit_bank_tb_top
